// >>> verif/dtxr_regs_props.sv
// assertion checker for the control register slice
`default_nettype none
module dtxr_regs_props (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire dtxr_pkg::dtxr_req_t regReq,
   input wire logic [7:0] regRdData,
   input wire logic transmit_enable_pin_0,
   input wire logic transmit_enable_pin_1,
   input wire logic calPassCond,
   input wire logic calFailCond,
   input wire logic pllLostCond,
   input wire logic ch0PowerDown,
   input wire logic ch1PowerDown,
   input wire logic irq_n
);
   logic [1:0] gate_r;
   logic [2:0] mode_r;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ************************************
   // shadow of written gate and mode bits
   // ************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_r <= 2'h0;
         mode_r <= 3'h0;
      end else if (regReq.wrEn && regReq.addr == dtxr_pkg::TXEN_GATING_ADDR) begin
         gate_r <= regReq.wrData[1:0];
      end else if (regReq.wrEn && regReq.addr == dtxr_pkg::LATCH_MODE0_ADDR) begin
         mode_r <= regReq.wrData[7:5];
      end
   end
   property p_pd0;
      ch0PowerDown == ($past(gate_r[0]) && !$past(transmit_enable_pin_0));
   endproperty
   a_pd0: assert property (p_pd0) else $error("ch0 power down wrong");
   property p_pd1;
      ch1PowerDown == ($past(gate_r[1]) && !$past(transmit_enable_pin_1));
   endproperty
   a_pd1: assert property (p_pd1) else $error("ch1 power down wrong");
   property p_pass;
      $rose(calPassCond) && mode_r[2] |=> !irq_n;
   endproperty
   a_pass: assert property (p_pass) else $error("pass event not latched");
   property p_fail;
      $rose(calFailCond) && mode_r[1] |=> !irq_n;
   endproperty
   a_fail: assert property (p_fail) else $error("fail event not latched");
   property p_lost;
      $rose(pllLostCond) && mode_r[0] |=> !irq_n;
   endproperty
   a_lost: assert property (p_lost) else $error("pll loss not latched");
   property p_quiet;
      (mode_r == 3'h0) [*3] |-> irq_n;
   endproperty
   a_quiet: assert property (p_quiet) else $error("interrupt with modes off");
   property p_rdmode;
      regReq.rdEn && regReq.addr == dtxr_pkg::LATCH_MODE0_ADDR |=> regRdData == {$past(mode_r), 5'h00};
   endproperty
   a_rdmode: assert property (p_rdmode) else $error("mode readback wrong");
   property p_rdgate;
      regReq.rdEn && regReq.addr == dtxr_pkg::TXEN_GATING_ADDR |=> regRdData == {6'h00, $past(gate_r)};
   endproperty
   a_rdgate: assert property (p_rdgate) else $error("gate readback wrong");
   property p_rdpage;
      regReq.rdEn && regReq.addr == dtxr_pkg::PAGE_SELECT_ADDR |=> regRdData[7:2] == 6'h00;
   endproperty
   a_rdpage: assert property (p_rdpage) else $error("page reserved bits set");
   property p_rdnone;
      regReq.rdEn && regReq.addr == 8'h30 |=> regRdData == 8'h00;
   endproperty
   a_rdnone: assert property (p_rdnone) else $error("unmapped read not zero");
   c_irq: cover property (!irq_n);
   c_pd0: cover property (ch0PowerDown);
   c_pd1: cover property (ch1PowerDown);
endmodule : dtxr_regs_props
bind dtxr_regs dtxr_regs_props dtxr_regs_props_i (.sys_clk, .rst_n, .regReq, .regRdData,
   .transmit_enable_pin_0, .transmit_enable_pin_1, .calPassCond, .calFailCond, .pllLostCond,
   .ch0PowerDown, .ch1PowerDown, .irq_n);
`default_nettype wire

// >>> verif/tb_dtxr_regs.sv
// self-checking bench for the control register slice
`default_nettype none
module tb_dtxr_regs;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   dtxr_pkg::dtxr_req_t regReq = '0;
   logic [7:0] regRdData;
   logic [1:0] txPin = 2'h3;
   logic [2:0] cond = 3'h0;
   logic [15:0] smpIn = 16'h0000;
   logic [15:0] out0;
   logic [15:0] out1;
   logic pd0;
   logic pd1;
   logic irqN;
   int num_errors = 0;
   int tests_run = 0;
   // clock and device
   always #12.5 sys_clk = ~sys_clk;
   dtxr_regs dtxr_regs_i (.sys_clk, .rst_n, .regReq, .regRdData,
      .transmit_enable_pin_0(txPin[0]), .transmit_enable_pin_1(txPin[1]),
      .calPassCond(cond[2]), .calFailCond(cond[1]), .pllLostCond(cond[0]),
      .ch0SampleIn(smpIn), .ch1SampleIn(smpIn), .ch0SampleOut(out0), .ch1SampleOut(out1),
      .ch0PowerDown(pd0), .ch1PowerDown(pd1), .irq_n(irqN));
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regReq = '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
      tick(1);
      regReq = '0;
      tick(1);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      regReq = '{addr: a, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
      tick(1);
      regReq = '0;
      chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, regRdData});
      tick(1);
   endtask : rchk
   // step both channels and time the outputs
   task automatic step(input int e0, input int e1, input logic [15:0] ev);
      int f0 = 0;
      int f1 = 0;
      logic [15:0] v0 = 16'hFFFF;
      smpIn = 16'h1000;
      for (int n = 1; n <= 12; n++) begin
         tick(1);
         if (out0 !== 16'h0000 && v0 === 16'hFFFF) v0 = out0;
         if (out0 === 16'h1000 && f0 == 0) f0 = n;
         if (out1 === 16'h1000 && f1 == 0) f1 = n;
      end
      smpIn = 16'h0000;
      tick(12);
      chk("ch0 full", 16'(e0), 16'(f0));
      chk("ch1 full", 16'(e1), 16'(f1));
      chk("ch0 first", ev, v0);
   endtask : step
   task automatic t_reset;
      rchk(8'h08, 8'h03);
      rchk(8'h12, 8'h00);
      rchk(8'h14, 8'h08);
      rchk(8'h1F, 8'h00);
      rchk(8'h30, 8'h00);
   endtask : t_reset
   task automatic t_gate;
      wr(8'h13, 8'hFF);
      rchk(8'h13, 8'h2C);
      wr(8'h12, 8'hFF);
      rchk(8'h12, 8'h03);
      txPin = 2'b10;
      tick(1);
      chk("pd0 low pin", 16'h1, {15'h0, pd0});
      chk("pd1 high pin", 16'h0, {15'h0, pd1});
      txPin = 2'b01;
      tick(1);
      chk("pd1 low pin", 16'h1, {15'h0, pd1});
      wr(8'h12, 8'h00);
      txPin = 2'b00;
      tick(1);
      chk("pd ungated", 16'h0, {14'h0, pd1, pd0});
      txPin = 2'b11;
   endtask : t_gate
   task automatic t_delay;
      wr(8'h08, 8'h01);
      for (int c = 0; c < 16; c++) begin
         wr(8'h14, 8'(c));
         rchk(8'h14, 8'(c));
      end
      wr(8'h14, 8'h01);
      wr(8'h08, 8'h02);
      wr(8'h14, 8'h0F);
      rchk(8'h14, 8'h0F);
      wr(8'h08, 8'h03);
      rchk(8'h14, 8'h01);
      step(3, 10, 16'h0800);
      wr(8'h14, 8'h00);
      step(2, 2, 16'h1000);
   endtask : t_delay
   task automatic t_irq;
      logic [7:0] m;
      for (int i = 0; i < 3; i++) begin
         m = 8'h80 >> i;
         wr(8'h1F, m);
         cond[2-i] = 1'b1;
         tick(1);
         chk("irq set", 16'h0, {15'h0, irqN});
         cond = 3'h0;
         tick(2);
         chk("irq held", 16'h0, {15'h0, irqN});
         rchk(8'h24, m);
         wr(8'h24, m);
         chk("irq cleared", 16'h1, {15'h0, irqN});
         wr(8'h1F, 8'h00);
         cond[2-i] = 1'b1;
         tick(2);
         chk("irq quiet", 16'h1, {15'h0, irqN});
         rchk(8'h24, m);
         cond = 3'h0;
         tick(2);
         rchk(8'h24, 8'h00);
      end
      // a rise in the clearing cycle still latches
      wr(8'h1F, 8'h80);
      regReq = '{addr: 8'h24, wrData: 8'h80, wrEn: 1'b1, rdEn: 1'b0};
      cond[2] = 1'b1;
      tick(1);
      regReq = '0;
      cond = 3'h0;
      chk("irq set wins", 16'h0, {15'h0, irqN});
      wr(8'h24, 8'h80);
      chk("irq set cleared", 16'h1, {15'h0, irqN});
      wr(8'h1F, 8'h00);
   endtask : t_irq
   task automatic print_verdict;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   // watchdog against a hung run
   initial begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      print_verdict();
   end
   // main sequence
   initial begin
      tick(4);
      rst_n = 1'b1;
      tick(1);
      t_reset();
      t_gate();
      t_delay();
      t_irq();
      print_verdict();
   end
endmodule : tb_dtxr_regs
`default_nettype wire

// >>> verilog/dtxr_chan_delay.sv
// one converter channel's half-step group delay line
`default_nettype none
module dtxr_chan_delay #(
   parameter int DATA_W = 16,
   parameter int DEPTH = 9
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [DATA_W-1:0] sampleIn,
   input wire logic [3:0] delayCode,
   output logic [DATA_W-1:0] sampleOut
);
   logic [DATA_W-1:0] tap_r [DEPTH];
   logic [DATA_W-1:0] whole;
   logic [DATA_W-1:0] later;
   logic [DATA_W:0] pairSum;
   logic [DATA_W-1:0] sampleOut_nxt;

   // ****************************************
   // shift line, one tap per converter clock
   // ****************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            tap_r[i] <= '0;
         end
      end else begin
         tap_r[0] <= sampleIn;
         for (int i = 1; i < DEPTH; i++) begin
            tap_r[i] <= tap_r[i-1];
         end
      end
   end

   // ****************************************
   // tap select and half-period interpolation
   // ****************************************
   // code zero shortest delay
   always_comb begin
      whole = tap_r[delayCode[3:1]];
      later = tap_r[{1'b0, delayCode[3:1]} + 4'h1]; // widened so the top code reaches the last tap
      pairSum = {1'b0, whole} + {1'b0, later};
      sampleOut_nxt = delayCode[0] ? pairSum[DATA_W:1] : whole; // mean of neighbours sits half a period later
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sampleOut <= '0;
      end else begin
         sampleOut <= sampleOut_nxt;
      end
   end
endmodule : dtxr_chan_delay
`default_nettype wire

// >>> verilog/dtxr_pkg.sv
// constants and types shared by the converter control register slice
`default_nettype none
package dtxr_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] PAGE_SELECT_ADDR = 8'h08;
   localparam logic [7:0] TXEN_GATING_ADDR = 8'h12;
   localparam logic [7:0] PWR_PROTECT_ADDR = 8'h13;
   localparam logic [7:0] OUT_DELAY_ADDR = 8'h14;
   localparam logic [7:0] LATCH_MODE0_ADDR = 8'h1F;
   localparam logic [7:0] EVENT_STATUS_ADDR = 8'h24;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CH0_GATE_BIT = 0;
   localparam int CH1_GATE_BIT = 1;
   localparam int SPI_PROTECT_BIT = 2;
   localparam int SPI_PROTECT_OUT_BIT = 3;
   localparam int TX_PROTECT_OUT_BIT = 5;
   localparam int PLL_LOST_BIT = 5;
   localparam int CAL_FAIL_BIT = 6;
   localparam int CAL_PASS_BIT = 7;
   localparam int DELAY_CODE_W = 4;

   // ****************************************
   // reset values and masks
   // ****************************************
   localparam logic [1:0] PAGE_RESET = 2'h3;
   localparam logic [1:0] PAGE_CH0 = 2'h1;
   localparam logic [1:0] PAGE_CH1 = 2'h2;
   localparam logic [1:0] PAGE_BOTH = 2'h3;
   localparam logic [3:0] DELAY_RESET = 4'h8;
   localparam int DELAY_TAPS = 9; // taps needed to reach the longest delay code
   localparam logic [7:0] PWR_PROTECT_MASK = 8'h2C;
   localparam logic [7:0] LATCH_MODE_MASK = 8'hE0;
   localparam logic [7:0] GATE_MASK = 8'h03;

   // ****************************************
   // register access request
   // ****************************************
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wrData;
      logic wrEn;
      logic rdEn;
   } dtxr_req_t;

   typedef enum logic [1:0] {
      DTXR_TGT_NONE,
      DTXR_TGT_CH0,
      DTXR_TGT_CH1,
      DTXR_TGT_BOTH
   } dtxr_target_t;
endpackage : dtxr_pkg
`default_nettype wire

// >>> verilog/dtxr_regs.sv
// control registers for transmit-enable gating, group delay and event status modes
`default_nettype none
module dtxr_regs #(
   parameter int DATA_W = 16
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire dtxr_pkg::dtxr_req_t regReq,
   output logic [7:0] regRdData,
   input wire logic transmit_enable_pin_0,
   input wire logic transmit_enable_pin_1,
   input wire logic calPassCond,
   input wire logic calFailCond,
   input wire logic pllLostCond,
   input wire logic [DATA_W-1:0] ch0SampleIn,
   input wire logic [DATA_W-1:0] ch1SampleIn,
   output logic [DATA_W-1:0] ch0SampleOut,
   output logic [DATA_W-1:0] ch1SampleOut,
   output logic ch0PowerDown,
   output logic ch1PowerDown,
   output logic irq_n
);
   logic [1:0] pageSel_r;
   logic [7:0] gating_r;
   logic [7:0] protect0_r;
   logic [7:0] protect1_r;
   logic [3:0] delay0_r;
   logic [3:0] delay1_r;
   logic [7:0] latchMode_r;
   logic [2:0] condPrev_r;
   logic [2:0] latched_r;
   logic [2:0] cond;
   logic [2:0] mode;
   logic [2:0] rise;
   logic [2:0] clearReq;
   logic [2:0] latched_nxt;
   logic [2:0] shown;
   logic wrCh0;
   logic wrCh1;
   logic rdCh1;
   logic [7:0] rdMux;
   dtxr_pkg::dtxr_target_t target;

   // ****************************************
   // page decode
   // ****************************************
   // page steers paged access
   always_comb begin
      case (pageSel_r)
         dtxr_pkg::PAGE_CH0: target = dtxr_pkg::DTXR_TGT_CH0;
         dtxr_pkg::PAGE_CH1: target = dtxr_pkg::DTXR_TGT_CH1;
         dtxr_pkg::PAGE_BOTH: target = dtxr_pkg::DTXR_TGT_BOTH;
         default: target = dtxr_pkg::DTXR_TGT_NONE;
      endcase
      wrCh0 = (target == dtxr_pkg::DTXR_TGT_CH0) || (target == dtxr_pkg::DTXR_TGT_BOTH);
      wrCh1 = (target == dtxr_pkg::DTXR_TGT_CH1) || (target == dtxr_pkg::DTXR_TGT_BOTH);
      rdCh1 = (target == dtxr_pkg::DTXR_TGT_CH1); // both-page reads come from channel 0
   end

   // ****************************************
   // plain control registers
   // ****************************************
   // reserved bits dropped on write
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pageSel_r <= dtxr_pkg::PAGE_RESET;
         gating_r <= 8'h00;
         latchMode_r <= 8'h00;
      end else if (regReq.wrEn) begin
         if (regReq.addr == dtxr_pkg::PAGE_SELECT_ADDR) begin
            pageSel_r <= regReq.wrData[1:0];
         end
         if (regReq.addr == dtxr_pkg::TXEN_GATING_ADDR) begin
            gating_r <= regReq.wrData & dtxr_pkg::GATE_MASK;
         end
         if (regReq.addr == dtxr_pkg::LATCH_MODE0_ADDR) begin
            latchMode_r <= regReq.wrData & dtxr_pkg::LATCH_MODE_MASK;
         end
      end
   end

   // ****************************************
   // paged per-channel registers
   // ****************************************
   // each channel keeps its own delay
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         protect0_r <= 8'h00;
         protect1_r <= 8'h00;
         delay0_r <= dtxr_pkg::DELAY_RESET;
         delay1_r <= dtxr_pkg::DELAY_RESET;
      end else if (regReq.wrEn) begin
         if (regReq.addr == dtxr_pkg::PWR_PROTECT_ADDR && wrCh0) begin
            protect0_r <= regReq.wrData & dtxr_pkg::PWR_PROTECT_MASK;
         end
         if (regReq.addr == dtxr_pkg::PWR_PROTECT_ADDR && wrCh1) begin
            protect1_r <= regReq.wrData & dtxr_pkg::PWR_PROTECT_MASK;
         end
         if (regReq.addr == dtxr_pkg::OUT_DELAY_ADDR && wrCh0) begin
            delay0_r <= regReq.wrData[dtxr_pkg::DELAY_CODE_W-1:0];
         end
         if (regReq.addr == dtxr_pkg::OUT_DELAY_ADDR && wrCh1) begin
            delay1_r <= regReq.wrData[dtxr_pkg::DELAY_CODE_W-1:0];
         end
      end
   end

   // ****************************************
   // transmit-enable power gating
   // ****************************************
   // a fall of the pin is the first low cycle, so the level form covers the edge and the hold
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ch0PowerDown <= 1'b0;
         ch1PowerDown <= 1'b0;
      end else begin
         ch0PowerDown <= gating_r[dtxr_pkg::CH0_GATE_BIT] & ~transmit_enable_pin_0;
         ch1PowerDown <= gating_r[dtxr_pkg::CH1_GATE_BIT] & ~transmit_enable_pin_1;
      end
   end

   // ****************************************
   // event flags: latched or live
   // ****************************************
   always_comb begin
      cond = {calPassCond, calFailCond, pllLostCond};
      mode = {latchMode_r[dtxr_pkg::CAL_PASS_BIT], latchMode_r[dtxr_pkg::CAL_FAIL_BIT],
              latchMode_r[dtxr_pkg::PLL_LOST_BIT]};
      rise = cond & ~condPrev_r;
      clearReq = (regReq.wrEn && regReq.addr == dtxr_pkg::EVENT_STATUS_ADDR) ? regReq.wrData[7:5] : 3'h0;
      latched_nxt = mode & (rise | (latched_r & ~clearReq)); // a new rise beats a clear
      shown = (mode & latched_r) | (~mode & cond); // clear mode shows live condition
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         condPrev_r <= 3'h0;
         latched_r <= 3'h0;
      end else begin
         condPrev_r <= cond;
         latched_r <= latched_nxt;
      end
   end

   // interrupt low while any latched flag stands
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_n <= 1'b1;
      end else begin
         irq_n <= ~|latched_nxt;
      end
   end

   // ****************************************
   // read-back
   // ****************************************
   // reserved bits read zero
   always_comb begin
      case (regReq.addr)
         dtxr_pkg::PAGE_SELECT_ADDR: rdMux = {6'h00, pageSel_r};
         dtxr_pkg::TXEN_GATING_ADDR: rdMux = gating_r;
         dtxr_pkg::PWR_PROTECT_ADDR: rdMux = rdCh1 ? protect1_r : protect0_r;
         dtxr_pkg::OUT_DELAY_ADDR: rdMux = {4'h0, rdCh1 ? delay1_r : delay0_r};
         dtxr_pkg::LATCH_MODE0_ADDR: rdMux = latchMode_r;
         dtxr_pkg::EVENT_STATUS_ADDR: rdMux = {shown, 5'h00};
         default: rdMux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= 8'h00;
      end else if (regReq.rdEn) begin
         regRdData <= rdMux;
      end
   end

   // ****************************************
   // per-channel delay lines
   // ****************************************
   dtxr_chan_delay #(.DATA_W(DATA_W), .DEPTH(dtxr_pkg::DELAY_TAPS)) u_delay0 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .sampleIn(ch0SampleIn),
      .delayCode(delay0_r),
      .sampleOut(ch0SampleOut)
   );

   dtxr_chan_delay #(.DATA_W(DATA_W), .DEPTH(dtxr_pkg::DELAY_TAPS)) u_delay1 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .sampleIn(ch1SampleIn),
      .delayCode(delay1_r),
      .sampleOut(ch1SampleOut)
   );
endmodule : dtxr_regs
`default_nettype wire

// >>> verilog/unused_placeholder_none.sv
// intentionally empty design file
`default_nettype none
`default_nettype wire
